/* rtl/backplane_defines.svh */
// What this block and the bus around it do
// [R1] Slave holds request low until acknowledged
// [R2] Grant requests only at instruction boundary
// [R3] Assert input strobe, then grant out
// [R4] Idle slaves pass grant down chain
// [R5] Requester blocks grant, replies with vector
// [R6] On reply release strobe, grant; vector out
// [R7] Software reset drives initialize about 10 us
// [R8] Slaves clear state on initialize
// [R9] Hold initialize while dc power low
// [R10] Source raises dc good 3 ms late
// [R11] Dc good releases initialize, await ac good
// [R12] Ac good rises 70 ms after dc
// [R13] Ac good starts power-up or console
// [R14] Ac loss traps through 024/026
// [R15] Dc loss asserts initialize
// [R16] 64 refresh transactions every 2 ms
// [R17] Refresh strobe during address phase
// [R18] Memories all enable under refresh strobe
// [R19] Row address bits 1-6 step per transaction
// [R20] Refresh sequence about 130 us
// [R21] No reply in 10 us traps to 4
//
// Purpose: constants for the backplane control block
// Assumes: 10 MHz clock
// Notes:   times in ns, counts derived
`ifndef BACKPLANE_DEFINES_SVH
`define BACKPLANE_DEFINES_SVH
`define CLK_PERIOD_NS     100
`define INIT_PULSE_NS     10000
`define INIT_PULSE_CYC    (`INIT_PULSE_NS / `CLK_PERIOD_NS)
`define REPLY_TIMEOUT_NS  10000
`define REPLY_TIMEOUT_CYC (`REPLY_TIMEOUT_NS / `CLK_PERIOD_NS)
`define REFRESH_PERIOD_NS 2000000
`define REFRESH_PERIOD_CYC (`REFRESH_PERIOD_NS / `CLK_PERIOD_NS)
`define REFRESH_SEQ_NS    130000
`define REFRESH_SEQ_CYC   (`REFRESH_SEQ_NS / `CLK_PERIOD_NS)
`define REFRESH_ROWS      64
`define ROW_LSB           1
`define TRAP_TIMEOUT_VEC  16'h0004
`define TRAP_PWRFAIL_PC   16'h0014
`define TRAP_PWRFAIL_PS   16'h0016
`endif

/* rtl/backplane_pkg.sv */
// Purpose: types for the backplane control block
// Assumes: nothing
// Notes:   events reported to the sequencer core
package backplane_pkg;
	typedef enum logic [1:0] {EV_NONE, EV_VECTOR, EV_TIMEOUT, EV_PWRFAIL} event_e;
	typedef struct packed {
		event_e      kind;
		logic [15:0] addr;
	} event_s;
endpackage

/* rtl/backplane_irq_init_refresh.sv */
// Purpose: interrupt acknowledge, bus init, power sequence, refresh
// Assumes: inputs synchronous to clock; data lines as in/out/oe
// Notes:   vector and trap addresses reported on evt_r
`timescale 1ns/1ps
`include "backplane_defines.svh"
module backplane_irq_init_refresh #(
	parameter int REFRESH_PERIOD_CYC = `REFRESH_PERIOD_CYC,
	parameter int INIT_PULSE_CYC     = `INIT_PULSE_CYC,
	parameter int REPLY_TIMEOUT_CYC  = `REPLY_TIMEOUT_CYC
) (
	input  wire logic                 clock,                 // System clock
	input  wire logic                 rstn,                  // Sync reset
	input  wire logic                 instr_boundary,        // Between instructions
	input  wire logic                 reset_instr,           // Software reset pulse
	input  wire logic                 irq_request_n,         // Interrupt request
	input  wire logic                 slave_reply_n,         // Reply
	input  wire logic [15:0]          muxed_data_addr_in,    // Data lines in
	input  wire logic                 dc_power_good,         // Dc good
	input  wire logic                 ac_power_good,         // Ac good
	input  wire logic                 halt_request_n,        // Halt
	output logic                      data_input_strobe_n,   // Input strobe
	output logic                      irq_grant_out_n,       // Grant out
	output logic                      cycle_sync_n,          // Sync
	output logic                      refresh_strobe_n,      // Refresh strobe
	output logic                      bus_initialize_n,      // Initialize
	output logic [15:0]               muxed_data_addr_out,   // Data lines out
	output logic                      muxed_data_addr_oe,    // Drive data lines
	output logic                      run_r,                 // Processor running
	output logic                      console_r,             // Console mode
	output backplane_pkg::event_s     evt_r                  // One-cycle event
);
	// ****************************************
	// Bus sequencer
	// ****************************************
	typedef enum logic [2:0] {S_IDLE, S_IAK_DIN, S_IAK_GRANT, S_REF_ADDR, S_REF_DIN, S_REF_END} bus_state_e;
	bus_state_e  st_r;
	logic [15:0] tmo_r;
	logic [5:0]  row_r;
	logic [6:0]  ref_left_r;
	logic [21:0] ref_tmr_r;
	logic        ref_due_r;
	logic        powered_r;
	logic        ac_prev_r;
	logic [15:0] din_wait_r;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_r                <= S_IDLE;
			data_input_strobe_n <= 1'b1;
			irq_grant_out_n     <= 1'b1;
			cycle_sync_n        <= 1'b1;
			refresh_strobe_n    <= 1'b1;
			muxed_data_addr_out <= 16'h0000;
			muxed_data_addr_oe  <= 1'b0;
			tmo_r               <= 16'h0000;
			row_r               <= 6'h00;
			ref_left_r          <= 7'h00;
			evt_r               <= '{backplane_pkg::EV_NONE, 16'h0000};
		end else begin
			evt_r <= '{backplane_pkg::EV_NONE, 16'h0000};
			case (st_r)
				S_IDLE: begin
					tmo_r <= 16'h0000;
					if (ref_due_r && powered_r) begin
						ref_left_r          <= 7'(`REFRESH_ROWS);
						st_r                <= S_REF_ADDR;
					end else if (run_r && instr_boundary && !irq_request_n) begin // [R2]
						data_input_strobe_n <= 1'b0; // [R3]
						st_r                <= S_IAK_DIN;
					end
				end
				S_IAK_DIN: begin
					irq_grant_out_n <= 1'b0; // [R3]
					st_r            <= S_IAK_GRANT;
				end
				S_IAK_GRANT: begin
					tmo_r <= tmo_r + 16'h0001;
					if (!slave_reply_n) begin // [R6]
						data_input_strobe_n <= 1'b1;
						irq_grant_out_n     <= 1'b1;
						evt_r               <= '{backplane_pkg::EV_VECTOR, muxed_data_addr_in};
						st_r                <= S_IDLE;
					end else if (tmo_r >= 16'(REPLY_TIMEOUT_CYC - 1)) begin // [R21]
						data_input_strobe_n <= 1'b1;
						irq_grant_out_n     <= 1'b1;
						evt_r               <= '{backplane_pkg::EV_TIMEOUT, `TRAP_TIMEOUT_VEC};
						st_r                <= S_IDLE;
					end
				end
				S_REF_ADDR: begin
					refresh_strobe_n    <= 1'b0; // [R17]
					cycle_sync_n        <= 1'b0;
					muxed_data_addr_oe  <= 1'b1;
					muxed_data_addr_out <= {9'h000, row_r, 1'b0}; // [R19]
					tmo_r               <= 16'h0000;
					st_r                <= S_REF_DIN;
				end
				S_REF_DIN: begin
					refresh_strobe_n    <= 1'b1;
					muxed_data_addr_oe  <= 1'b0;
					data_input_strobe_n <= 1'b0;
					tmo_r               <= tmo_r + 16'h0001;
					if (!data_input_strobe_n && !slave_reply_n) begin
						data_input_strobe_n <= 1'b1;
						cycle_sync_n        <= 1'b1;
						st_r                <= S_REF_END;
					end else if (tmo_r >= 16'(REPLY_TIMEOUT_CYC - 1)) begin // [R21]
						data_input_strobe_n <= 1'b1;
						cycle_sync_n        <= 1'b1;
						evt_r               <= '{backplane_pkg::EV_TIMEOUT, `TRAP_TIMEOUT_VEC};
						st_r                <= S_IDLE;
					end
				end
				S_REF_END: begin
					row_r      <= row_r + 6'h01; // [R19]
					ref_left_r <= ref_left_r - 7'h01;
					st_r       <= (ref_left_r == 7'h01) ? S_IDLE : S_REF_ADDR; // [R16] [R20]
				end
				default: st_r <= S_IDLE;
			endcase
			// Power-fail trap outranks any other event of the same cycle
			if (dc_power_good && run_r && !ac_power_good && ac_prev_r) // [R14]
				evt_r <= '{backplane_pkg::EV_PWRFAIL, `TRAP_PWRFAIL_PC};
		end
	end

	// ****************************************
	// Refresh interval timer
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ref_tmr_r <= 22'h000000;
			ref_due_r <= 1'b0;
		end else begin
			if (ref_tmr_r >= 22'(REFRESH_PERIOD_CYC - `REFRESH_SEQ_CYC - 1)) begin // [R16]
				ref_tmr_r <= 22'h000000;
				ref_due_r <= 1'b1;
			end else begin
				ref_tmr_r <= ref_tmr_r + 22'h000001;
				if (st_r == S_REF_ADDR)
					ref_due_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Power sequence and initialize
	// ****************************************
	logic [15:0] init_cnt_r;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			bus_initialize_n <= 1'b0;
			init_cnt_r       <= 16'h0000;
			powered_r        <= 1'b0;
			run_r            <= 1'b0;
			console_r        <= 1'b0;
			ac_prev_r        <= 1'b0;
		end else begin
			ac_prev_r <= ac_power_good;
			if (!dc_power_good) begin
				bus_initialize_n <= 1'b0; // [R9] [R15]
				powered_r        <= 1'b0;
				run_r            <= 1'b0;
				console_r        <= 1'b0;
				init_cnt_r       <= 16'h0000;
			end else if (!powered_r) begin
				bus_initialize_n <= 1'b1; // [R11]
				powered_r        <= 1'b1;
			end else if (init_cnt_r != 16'h0000) begin
				init_cnt_r <= init_cnt_r - 16'h0001;
				if (init_cnt_r == 16'h0001)
					bus_initialize_n <= 1'b1;
			end else if (reset_instr && run_r) begin
				bus_initialize_n <= 1'b0; // [R7]
				init_cnt_r       <= 16'(INIT_PULSE_CYC);
			end
			if (dc_power_good && powered_r && ac_power_good && !ac_prev_r) begin // [R13]
				run_r     <= halt_request_n;
				console_r <= !halt_request_n;
			end else if (dc_power_good && !ac_power_good && ac_prev_r) begin // [R14]
				run_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_grant_after_strobe: assert property (@(posedge clock) disable iff (!rstn) // [R3]
		$fell(irq_grant_out_n) |-> !data_input_strobe_n && $past(!data_input_strobe_n))
		else $error("grant without prior strobe");
	a_grant_at_boundary: assert property (@(posedge clock) disable iff (!rstn) // [R2]
		$fell(data_input_strobe_n) && st_r == S_IAK_DIN |-> $past(instr_boundary))
		else $error("grant off boundary");
	a_release_on_reply: assert property (@(posedge clock) disable iff (!rstn) // [R6]
		st_r == S_IAK_GRANT && !slave_reply_n |=> irq_grant_out_n && data_input_strobe_n
		&& evt_r.kind == backplane_pkg::EV_VECTOR)
		else $error("not released on reply");
	a_init_pulse_len: assert property (@(posedge clock) disable iff (!rstn) // [R7]
		$rose(init_cnt_r != 16'h0000) && dc_power_good |-> !bus_initialize_n [*8])
		else $error("init pulse short");
	a_init_dc_low: assert property (@(posedge clock) disable iff (!rstn) // [R9]
		!dc_power_good |=> !bus_initialize_n)
		else $error("init not held with dc low");
	a_init_release: assert property (@(posedge clock) disable iff (!rstn) // [R11]
		dc_power_good && !powered_r |=> bus_initialize_n)
		else $error("init not released");
	a_power_up: assert property (@(posedge clock) disable iff (!rstn) // [R13]
		dc_power_good && powered_r && ac_power_good && !ac_prev_r |=> run_r == $past(halt_request_n))
		else $error("power-up mode wrong");
	a_power_fail: assert property (@(posedge clock) disable iff (!rstn) // [R14]
		dc_power_good && !ac_power_good && ac_prev_r |=> !run_r)
		else $error("no stop on ac loss");
	a_pwrfail_trap: assert property (@(posedge clock) disable iff (!rstn) // [R14]
		dc_power_good && run_r && !ac_power_good && ac_prev_r
		|=> evt_r.kind == backplane_pkg::EV_PWRFAIL && evt_r.addr == `TRAP_PWRFAIL_PC)
		else $error("no power-fail trap");
	a_refresh_row: assert property (@(posedge clock) disable iff (!rstn) // [R19]
		st_r == S_REF_END |=> row_r == $past(row_r) + 6'h01)
		else $error("row not stepped");
	a_refresh_addr: assert property (@(posedge clock) disable iff (!rstn) // [R17]
		!refresh_strobe_n |-> !cycle_sync_n && muxed_data_addr_oe && data_input_strobe_n)
		else $error("refresh strobe outside address");
	// Cycles the input strobe has waited for a reply
	always_ff @(posedge clock) begin
		if (!rstn || data_input_strobe_n || !slave_reply_n)
			din_wait_r <= 16'h0000;
		else
			din_wait_r <= din_wait_r + 16'h0001;
	end
	a_reply_timeout: assert property (@(posedge clock) disable iff (!rstn) // [R21]
		din_wait_r <= 16'(REPLY_TIMEOUT_CYC + 1)
		&& (evt_r.kind != backplane_pkg::EV_TIMEOUT || evt_r.addr == `TRAP_TIMEOUT_VEC))
		else $error("strobe left without timeout trap");
	c_vector: cover property (@(posedge clock) disable iff (!rstn) evt_r.kind == backplane_pkg::EV_VECTOR);
	c_timeout: cover property (@(posedge clock) disable iff (!rstn) evt_r.kind == backplane_pkg::EV_TIMEOUT);
	c_refresh: cover property (@(posedge clock) disable iff (!rstn) st_r == S_REF_END && ref_left_r == 7'h01);
	c_console: cover property (@(posedge clock) disable iff (!rstn) $rose(console_r));
	c_pwrfail: cover property (@(posedge clock) disable iff (!rstn) evt_r.kind == backplane_pkg::EV_PWRFAIL);
endmodule

/* testbench/slave_model.sv */
// Purpose: far side of the bus: one requesting slave, memories, reply
// Assumes: master outputs registered on clock
// Notes:   released data lines toggle every cycle
`timescale 1ns/1ps
module slave_model (
	input  wire logic        clock,     // System clock
	input  wire logic        strobe_n,  // Input strobe from master
	input  wire logic        grant_n,   // Grant from master
	input  wire logic        refresh_n, // Refresh strobe from master
	input  wire logic        init_n,    // Bus initialize from master
	input  wire logic        irq_want,  // Bench wants an interrupt
	input  wire logic [15:0] vector,    // Vector to return
	input  wire logic [9:0]  delay,     // Reply delay in cycles
	output logic             irq_n,     // Request to master
	output logic             reply_n,   // Reply to master
	output logic [15:0]      data       // Data lines
);
	int   cnt;
	logic acked;
	logic sel;
	initial begin
		reply_n = 1'b1;
		data = 16'h0000;
		acked = 1'b0;
		sel = 1'b0;
		cnt = 0;
	end
	assign irq_n = !(irq_want && !acked);
	// Acts well after the edge, clear of the bench's input changes
	always @(posedge clock) begin
		#20;
		if (!irq_want) acked = 1'b0;
		if (!refresh_n) sel = 1'b1;
		if (strobe_n) begin
			if (!reply_n) sel = 1'b0;
			reply_n = 1'b1;
			cnt = 0;
		end else begin
			cnt++;
			if (sel && cnt > 1) reply_n = 1'b0;
			if (!sel && cnt > delay && !grant_n && !irq_n) reply_n = 1'b0;
		end
		if (!reply_n && !grant_n) acked = 1'b1;
		if (!init_n) acked = 1'b0;
		data = reply_n ? ~data : (grant_n ? 16'h0000 : vector);
	end
endmodule

/* testbench/backplane_irq_init_refresh_tb.sv */
// Purpose: self-checking bench for the backplane control block
// Assumes: refresh period shortened to 2000 cycles; supply delays scaled down
// Notes:   random vectors and reply delays from an LFSR seeded 73
`timescale 1ns/1ps
module backplane_irq_init_refresh_tb;
	logic clock = 1'b0, rstn = 1'b0, boundary = 1'b0, rst_ins = 1'b0, dc = 1'b0, ac = 1'b0, halt_n = 1'b1;
	logic irq_n, reply_n, strobe_n, grant_n, sync_n, ref_n, init_n, oe, run, cons, want = 1'b0, prev_strobe;
	logic [15:0] din, dout, vec = 16'h0000, rnd = 16'h0049;
	logic [9:0] dly = 10'd2;
	logic [5:0] row = 6'h0;
	logic [1:0] ekind;
	logic [15:0] eaddr;
	backplane_pkg::event_s evt;
	int num_errors = 0, checks = 0, ecnt = 0, rcnt = 0, i;
	always #50 clock = ~clock;
	backplane_irq_init_refresh #(.REFRESH_PERIOD_CYC(2000)) i_backplane_irq_init_refresh (
		.clock(clock), .rstn(rstn), .instr_boundary(boundary), .reset_instr(rst_ins),
		.irq_request_n(irq_n), .slave_reply_n(reply_n), .muxed_data_addr_in(din),
		.dc_power_good(dc), .ac_power_good(ac), .halt_request_n(halt_n),
		.data_input_strobe_n(strobe_n), .irq_grant_out_n(grant_n), .cycle_sync_n(sync_n),
		.refresh_strobe_n(ref_n), .bus_initialize_n(init_n), .muxed_data_addr_out(dout),
		.muxed_data_addr_oe(oe), .run_r(run), .console_r(cons), .evt_r(evt));
	slave_model i_slave_model (.clock(clock), .strobe_n(strobe_n), .grant_n(grant_n), .refresh_n(ref_n),
		.init_n(init_n), .irq_want(want), .vector(vec), .delay(dly), .irq_n(irq_n), .reply_n(reply_n), .data(din));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#10;
	endtask
	// Monitors: events and refresh address phases
	always @(negedge clock) begin
		prev_strobe <= strobe_n;
		if (evt.kind != backplane_pkg::EV_NONE) begin
			ekind = evt.kind;
			eaddr = evt.addr;
			ecnt++;
		end
		if (ref_n === 1'b0) begin
			check(dout, {9'h0, row, 1'b0});
			check({sync_n, oe}, 16'h1);
			row++;
			rcnt++;
		end
	end
	task automatic irq(input logic [9:0] d);
		rnd = lfsr(rnd);
		vec = rnd & 16'hfffc;
		dly = d;
		ecnt = 0;
		boundary = 1'b0;
		want = 1'b1;
		cyc(30);
		check(grant_n, 16'h1);
		boundary = 1'b1;
		for (i = 0; i < 3000 && grant_n !== 1'b0; i++) cyc(1);
		check(prev_strobe, 16'h0);
		for (i = 0; i < 300 && ecnt == 0; i++) cyc(1);
		check(16'(ecnt), 16'h0001);
		boundary = 1'b0;
		want = 1'b0;
		cyc(2);
	endtask
	initial begin
		#(100 * 30000);
		num_errors++;
		summarize();
	end
	initial begin
		cyc(16);
		rstn = 1'b1;
		cyc(20);
		check(init_n, 16'h0);
		dc = 1'b1;
		cyc(3);
		check({init_n, run}, 16'h2);
		ac = 1'b1;
		cyc(3);
		check({run, cons}, 16'h2);
		repeat (4) begin
			rnd = lfsr(rnd);
			irq(10'(rnd[2:0]) + 10'd2);
			check({14'h0, ekind}, 16'(backplane_pkg::EV_VECTOR));
			check(eaddr, vec);
			check({strobe_n, grant_n}, 16'h3);
		end
		irq(10'd1000);
		check({14'h0, ekind}, 16'(backplane_pkg::EV_TIMEOUT));
		check(eaddr, 16'h0004);
		dly = 10'd2;
		rcnt = 0;
		for (i = 0; i < 2000 && rcnt < 64; i++) cyc(1);
		check(16'(rcnt >= 64), 16'h1);
		rst_ins = 1'b1;
		cyc(1);
		rst_ins = 1'b0;
		for (i = 0; i < 5 && init_n !== 1'b0; i++) cyc(1);
		for (i = 0; i < 300 && init_n === 1'b0; i++) cyc(1);
		check(16'(i), 16'd100);
		ac = 1'b0;
		cyc(2);
		check(run, 16'h0);
		check({14'h0, ekind}, 16'(backplane_pkg::EV_PWRFAIL));
		check(eaddr, 16'h0014);
		dc = 1'b0;
		cyc(2);
		check(init_n, 16'h0);
		// Second power-up with halt held: console mode
		halt_n = 1'b0;
		dc = 1'b1;
		cyc(3);
		check({init_n, run}, 16'h2);
		ac = 1'b1;
		cyc(3);
		check({run, cons}, 16'h1);
		summarize();
	end
endmodule
